// ### hdl/cfm_cfg.svh
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH

// clock and fault timing
`define CFM_CLK_HZ         10000000
`define CFM_TXDOM_US       360
`define CFM_TXDOM_CYC      ((`CFM_TXDOM_US * (`CFM_CLK_HZ / 1000000)) - 1)
`define CFM_CNT_W          12

// spi frame layout, msb first
`define CFM_FRAME_W        8
`define CFM_ADDR_HI        7
`define CFM_ADDR_LO        5
`define CFM_RW_BIT         4
`define CFM_DATA_HI        3
`define CFM_DATA_LO        0
`define CFM_BITCNT_W       3
`define CFM_ADDR_DONE_CNT  3'h3
`define CFM_LAST_BIT_CNT   3'h7

// register addresses
`define CFM_ADDR_MCR       3'h0
`define CFM_ADDR_CAN       3'h1
`define CFM_ADDR_IOR       3'h2
`define CFM_ADDR_INTERRUPT_CONFIG_REGISTER      3'h3

// can status bit positions
`define CFM_CAN_OC_BIT     0
`define CFM_CAN_OT_BIT     1
`define CFM_CAN_TXF_BIT    2
`define CFM_CAN_SLP_BIT    3

// interrupt config bit positions
`define CFM_INT_CANF_BIT   0
`define CFM_INT_RAIL_BIT   1
`define CFM_INT_SWOT_BIT   2
`define CFM_INT_SUP_BIT    3

// misc bit positions and codes
`define CFM_IOR_RAIL_BIT   0
`define CFM_MCR_GLOBAL_FAILURE_FLAG_BIT  3
`define CFM_CAN_SLEEP_CMD  4'h3
`define CFM_NIB_ZERO       4'h0

`endif

// ### hdl/cfm_pkg.sv
package cfm_pkg;
	// spi shift phase
	typedef enum logic [1:0] {
		CFM_SPI_IDLE = 2'b01,
		CFM_SPI_SHIFT = 2'b10
	} cfm_spi_t;
endpackage

// ### hdl/cfm_can_fault_monitor.sv
//  Function
// - low peripheral rail sets rail-low flag
// - rail-low may raise interrupt if enabled
// - low rail blocks CAN transmit and receive
// - main rail undervoltage, rail fed from main: reset, rail-low flag
// - TX low beyond 360 us disables driver
// - driver re-enabled when TX returns high
// - dominant timeout latches CAN status bit D2
// - timeout bit clears after condition gone, read
// - timeout sets global failure, may interrupt
// - overtemperature disables driver, sets flag
// - overtemperature interrupts if enabled, global failure
// - no transmit while hot, auto re-enable
// - overtemp bit clears after cooled and read
// - overcurrent detected, reported in status bit
// - overcurrent sets global failure, may interrupt
// - overcurrent bit clears after gone and read
// - byte frame: 3 address, rw, 4 data
// - sleep command puts CAN asleep immediately
// - interrupt enables held in config register
`timescale 1ns/1ps
`include "cfm_cfg.svh"

module cfm_can_fault_monitor
	import cfm_pkg::*;
(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// pin-level monitor inputs, asynchronous
	input  wire logic tx_i,
	input  wire logic periph_rail_low_i,
	input  wire logic main_rail_uv_i,
	input  wire logic rail_from_main_i,
	input  wire logic driver_overtemp_i,
	input  wire logic driver_overcurrent_i,
	input  wire logic bus_rx_i,
	input  wire logic switch_overtemp_i,
	input  wire logic supply_low_i,
	// spi slave pins
	input  wire logic spi_cs_n_i,
	input  wire logic spi_sclk_i,
	input  wire logic spi_mosi_i,
	output logic      spi_miso_o,
	output logic      spi_miso_oe_o,
	// transceiver control and status
	output logic      driver_en_o,
	output logic      rx_o,
	output logic      can_sleep_o,
	output logic      reset_n_o,
	output logic      int_o,
	output logic      global_failure_flag_o,
	output logic      periph_rail_low_flag_o
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// every monitor pin and every spi pin crosses here
	// nothing downstream reads a raw pin
	// a level flipping near the edge settles in stage one
	// cost: a fixed latency, a pin change reaches
	// an output register on the third rising edge
	// so short glitches below one mclk may be missed
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
	assign async_in = {supply_low_i, switch_overtemp_i, bus_rx_i, spi_mosi_i, spi_sclk_i, spi_cs_n_i,
		driver_overcurrent_i, driver_overtemp_i, rail_from_main_i, main_rail_uv_i, periph_rail_low_i, tx_i};

	// two flops per pin; first stage feeds only the second
	always_comb begin
		sync1_nxt = async_in;
		sync2_nxt = sync1_r;
	end
	always_ff @(posedge mclk_i) begin
		sync1_r <= sync1_nxt;
		sync2_r <= sync2_nxt;
	end

	logic tx_s, rail_low_s, main_uv_s, from_main_s, ot_s, oc_s;
	logic cs_n_s, sclk_s, mosi_s, brx_s, swot_s, suplow_s;
	assign {suplow_s, swot_s, brx_s, mosi_s, sclk_s, cs_n_s, oc_s, ot_s, from_main_s, main_uv_s, rail_low_s,
		tx_s} = sync2_r;

	// ------------------------------------------------------------
	// spi frame receiver
	// ------------------------------------------------------------
	// sclk, mosi and cs_n are oversampled on mclk
	// limitation: sclk half period of two mclk at least,
	// or an sclk edge is lost and the frame slips
	// frame: three address bits, rw, four data bits, msb first
	// read data leaves on the last four bits, first four are zero
	// cs_n rising before the eighth sclk edge drops the frame
	// a dropped frame changes no register
	cfm_spi_t                  spi_st_r, spi_st_nxt;
	logic                      sclk_d_r, sclk_d_nxt;
	logic [`CFM_BITCNT_W-1:0]  bit_cnt_r, bit_cnt_nxt;
	logic [`CFM_FRAME_W-1:0]   sh_in_r, sh_in_nxt;
	logic [`CFM_FRAME_W-1:0]   sh_out_r, sh_out_nxt;
	logic                      miso_r, miso_nxt;
	logic                      oe_r, oe_nxt;
	logic                      frame_done;
	logic [`CFM_FRAME_W-1:0]   frame;
	logic [`CFM_DATA_HI:0]     rd_data;

	// read mux feeding only the shift-out load once the address bits are in
	function automatic logic [`CFM_DATA_HI:0] reg_read(input logic [2:0] a, input logic [3:0] canst,
		input logic [3:0] interrupt_config_register, input logic rl, input logic gf);
		unique case (a)
			`CFM_ADDR_CAN:  reg_read = canst;
			`CFM_ADDR_INTERRUPT_CONFIG_REGISTER: reg_read = interrupt_config_register;
			`CFM_ADDR_IOR:  reg_read = {3'h0, rl};
			`CFM_ADDR_MCR:  reg_read = {gf, 3'h0};
			default:        reg_read = `CFM_NIB_ZERO;
		endcase
	endfunction

	// sample on rising sclk, shift out on falling; mode 0, msb first
	always_comb begin
		spi_st_nxt  = spi_st_r;
		sclk_d_nxt  = sclk_s;
		bit_cnt_nxt = bit_cnt_r;
		sh_in_nxt   = sh_in_r;
		sh_out_nxt  = sh_out_r;
		miso_nxt    = miso_r;
		oe_nxt      = !cs_n_s;
		frame_done  = 1'b0;
		frame       = {sh_in_r[`CFM_FRAME_W-2:0], mosi_s};
		unique case (spi_st_r)
			CFM_SPI_IDLE: begin
				bit_cnt_nxt = '0;
				if (!cs_n_s) begin
					spi_st_nxt = CFM_SPI_SHIFT;
					sh_out_nxt = '0;
					miso_nxt   = 1'b0;
				end
			end
			CFM_SPI_SHIFT: begin
				if (cs_n_s) begin
					spi_st_nxt = CFM_SPI_IDLE;
				end else if (sclk_s && !sclk_d_r) begin
					sh_in_nxt   = frame;
					bit_cnt_nxt = bit_cnt_r + 3'h1;
					if (bit_cnt_r == `CFM_ADDR_DONE_CNT) begin
						// address and rw known: load read data for the low nibble
						sh_out_nxt = {`CFM_NIB_ZERO, rd_data};
					end
					if (bit_cnt_r == `CFM_LAST_BIT_CNT) begin
						frame_done = 1'b1;
					end
				end else if (!sclk_s && sclk_d_r) begin
					miso_nxt   = sh_out_r[`CFM_DATA_HI];
					sh_out_nxt = {sh_out_r[`CFM_FRAME_W-2:0], 1'b0};
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			spi_st_r  <= CFM_SPI_IDLE;
			sclk_d_r  <= 1'b0;
			bit_cnt_r <= '0;
			sh_in_r   <= '0;
			sh_out_r  <= '0;
			miso_r    <= 1'b0;
			oe_r      <= 1'b0;
		end else begin
			spi_st_r  <= spi_st_nxt;
			sclk_d_r  <= sclk_d_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			sh_in_r   <= sh_in_nxt;
			sh_out_r  <= sh_out_nxt;
			miso_r    <= miso_nxt;
			oe_r      <= oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// fault supervision and registers
	// ------------------------------------------------------------
	// each can fault bit is latched: its cause sets it,
	// a can status read clears it, and a cause still present
	// on that read sets it again in the same cycle
	// so a host reading too early sees the fault once more
	// rather than losing it
	// the dominant timeout counts mclk cycles of a low tx;
	// the driver returns as soon as tx is high, flag or not
	// the rail-low flag is sticky, cleared by an io status read
	logic [`CFM_CNT_W-1:0] dom_cnt_r, dom_cnt_nxt;
	logic                  txdom_r, txdom_nxt;
	logic [3:0]            can_st_r, can_st_nxt;
	logic [3:0]            interrupt_config_register_r, interrupt_config_register_nxt;
	logic                  rail_flag_r, rail_flag_nxt;
	logic                  global_failure_flag_r, global_failure_flag_nxt;
	logic                  int_r, int_nxt;
	logic                  drv_r, drv_nxt, rx_r, rx_nxt, rst_out_r, rst_out_nxt;
	logic                  rail_bad, wr, rd_can, rd_ior;
	logic [2:0]            addr;
	logic [3:0]            wdata;

	// completed read frame aimed at one register; shared by the clear-on-read flags
	function automatic logic rd_hit(input logic done, input logic [`CFM_FRAME_W-1:0] f, input logic [2:0] a);
		rd_hit = done && !f[`CFM_RW_BIT] && (f[`CFM_ADDR_HI:`CFM_ADDR_LO] == a);
	endfunction

	assign addr    = frame[`CFM_ADDR_HI:`CFM_ADDR_LO];
	assign wdata   = frame[`CFM_DATA_HI:`CFM_DATA_LO];
	assign wr      = frame_done && frame[`CFM_RW_BIT];
	assign rd_can  = rd_hit(frame_done, frame, `CFM_ADDR_CAN);
	assign rd_ior  = rd_hit(frame_done, frame, `CFM_ADDR_IOR);
	assign rd_data = reg_read(sh_in_r[2:0], can_st_r, interrupt_config_register_r, rail_flag_r, global_failure_flag_r);
	// a main-rail dip starves a rail fed from it, so it counts as low too
	assign rail_bad = rail_low_s || (from_main_s && main_uv_s);

	always_comb begin
		// count runs only while tx is low; any high restarts it
		dom_cnt_nxt = tx_s ? '0 : dom_cnt_r;
		txdom_nxt   = txdom_r;
		if (tx_s) begin
			txdom_nxt = 1'b0;
		end else if (dom_cnt_r == `CFM_CNT_W'(`CFM_TXDOM_CYC)) begin
			txdom_nxt = 1'b1;
		end else begin
			dom_cnt_nxt = dom_cnt_r + `CFM_CNT_W'(1);
		end
		can_st_nxt = can_st_r;
		interrupt_config_register_nxt   = interrupt_config_register_r;
		// read clears a bit only once its cause has gone; a live cause sets it again
		if (rd_can) begin
			can_st_nxt[`CFM_CAN_TXF_BIT] = 1'b0;
			can_st_nxt[`CFM_CAN_OT_BIT]  = 1'b0;
			can_st_nxt[`CFM_CAN_OC_BIT]  = 1'b0;
		end
		if (wr && addr == `CFM_ADDR_INTERRUPT_CONFIG_REGISTER) begin
			interrupt_config_register_nxt = wdata;
		end
		if (wr && addr == `CFM_ADDR_CAN) begin
			can_st_nxt[`CFM_CAN_SLP_BIT] = (wdata == `CFM_CAN_SLEEP_CMD);
		end
		if (txdom_nxt) begin
			can_st_nxt[`CFM_CAN_TXF_BIT] = 1'b1;
		end
		if (ot_s) begin
			can_st_nxt[`CFM_CAN_OT_BIT] = 1'b1;
		end
		if (oc_s) begin
			can_st_nxt[`CFM_CAN_OC_BIT] = 1'b1;
		end
		rail_flag_nxt = rail_bad || (rail_flag_r && !rd_ior);
		global_failure_flag_nxt     = |can_st_nxt[`CFM_CAN_OT_BIT:`CFM_CAN_OC_BIT] || can_st_nxt[`CFM_CAN_TXF_BIT];
		int_nxt       = (interrupt_config_register_r[`CFM_INT_CANF_BIT] && global_failure_flag_nxt)
			|| (interrupt_config_register_r[`CFM_INT_RAIL_BIT] && rail_flag_nxt)
			|| (interrupt_config_register_r[`CFM_INT_SWOT_BIT] && swot_s)
			|| (interrupt_config_register_r[`CFM_INT_SUP_BIT] && suplow_s);
		// driver off on timeout, heat, low rail or sleep; back on as each clears
		drv_nxt     = !txdom_nxt && !ot_s && !rail_bad && !can_st_nxt[`CFM_CAN_SLP_BIT];
		rx_nxt      = (rail_bad || can_st_nxt[`CFM_CAN_SLP_BIT]) ? 1'b1 : brx_s;
		rst_out_nxt = !(from_main_s && main_uv_s);
	end

	// registers only; every decision sits in the process above
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			dom_cnt_r   <= '0;
			txdom_r     <= 1'b0;
			can_st_r    <= `CFM_NIB_ZERO;
			interrupt_config_register_r      <= `CFM_NIB_ZERO;
			rail_flag_r <= 1'b0;
			global_failure_flag_r     <= 1'b0;
			int_r       <= 1'b0;
			drv_r       <= 1'b0;
			rx_r        <= 1'b1;
			rst_out_r   <= 1'b0;
		end else begin
			dom_cnt_r   <= dom_cnt_nxt;
			txdom_r     <= txdom_nxt;
			can_st_r    <= can_st_nxt;
			interrupt_config_register_r      <= interrupt_config_register_nxt;
			rail_flag_r <= rail_flag_nxt;
			global_failure_flag_r     <= global_failure_flag_nxt;
			int_r       <= int_nxt;
			drv_r       <= drv_nxt;
			rx_r        <= rx_nxt;
			rst_out_r   <= rst_out_nxt;
		end
	end

	// outputs straight from flops
	// every output is a register, so the host and the transceiver
	// never see a glitch from the decode above
	assign spi_miso_o             = miso_r;
	assign spi_miso_oe_o          = oe_r;
	assign driver_en_o            = drv_r;
	assign rx_o                   = rx_r;
	assign can_sleep_o            = can_st_r[`CFM_CAN_SLP_BIT];
	assign reset_n_o              = rst_out_r;
	assign int_o                  = int_r;
	assign global_failure_flag_o  = global_failure_flag_r;
	assign periph_rail_low_flag_o = rail_flag_r;

endmodule

// ### test/cfm_host_model.sv
`timescale 1ns/1ps
module cfm_host_model (
	// clock and returned data
	input  wire logic mclk_i,
	input  wire logic miso_i,
	input  wire logic oe_i,
	// spi master pins
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      mosi_o
);
	logic last_r = 1'h0;
	initial begin
		cs_n_o = 1'h1;
		sclk_o = 1'h0;
		mosi_o = 1'h0;
	end
	// ----
	// byte frame
	// ----
	// mode 0, half period of five clocks so the oversampler keeps up
	task automatic xfer(input logic [7:0] b, output logic [3:0] rd);
		cs_n_o = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			repeat (5) @(negedge mclk_i);
			sclk_o = 1'h0;
			mosi_o = b[i];
			repeat (5) @(negedge mclk_i);
			sclk_o = 1'h1;
			// undriven line shows the opposite of its last level
			last_r = oe_i ? miso_i : ~last_r;
			rd = {rd[2:0], last_r};
		end
		repeat (5) @(negedge mclk_i);
		sclk_o = 1'h0;
		repeat (5) @(negedge mclk_i);
		cs_n_o = 1'h1;
		repeat (5) @(negedge mclk_i);
	endtask
endmodule

// ### test/cfm_chk.sv
`timescale 1ns/1ps
module cfm_chk (
	// watched ports
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic tx_i,
	input wire logic periph_rail_low_i,
	input wire logic main_rail_uv_i,
	input wire logic rail_from_main_i,
	input wire logic driver_overtemp_i,
	input wire logic driver_overcurrent_i,
	input wire logic switch_overtemp_i,
	input wire logic supply_low_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_miso_oe_o,
	input wire logic driver_en_o,
	input wire logic can_sleep_o,
	input wire logic reset_n_o,
	input wire logic int_o,
	input wire logic global_failure_flag_o,
	input wire logic periph_rail_low_flag_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [12:0] low_r;
	logic [12:0] low_nxt;
	// dominant run length, saturating so it cannot wrap
	always_comb low_nxt = (!rst_n_i || tx_i) ? 13'h0000 : low_r + 13'h0001 - 13'(&low_r);
	always_ff @(posedge mclk_i) low_r <= low_nxt;
	chk_rail_flag: assert property (periph_rail_low_i [*6] |-> periph_rail_low_flag_o) else
		$error("rail flag missing");
	chk_main_uv: assert property ((main_rail_uv_i && rail_from_main_i) [*6] |->
		!reset_n_o && periph_rail_low_flag_o) else $error("undervoltage missed");
	chk_tx_cut: assert property (low_r >= 13'h0e1a |-> !driver_en_o) else
		$error("driver on after long dominant");
	chk_drv_back: assert property ((tx_i && !driver_overtemp_i && !periph_rail_low_i &&
		!main_rail_uv_i && !can_sleep_o) [*6] |-> driver_en_o) else $error("driver not back");
	chk_ot_off: assert property (driver_overtemp_i [*6] |-> !driver_en_o && global_failure_flag_o) else
		$error("overtemp not handled");
	chk_oc_fail: assert property (driver_overcurrent_i [*6] |-> global_failure_flag_o) else
		$error("overcurrent not flagged");
	chk_fail_clear: assert property ($fell(global_failure_flag_o) |-> !$past(spi_cs_n_i, 4)) else
		$error("failure cleared without read");
	chk_irq_quiet: assert property ((!global_failure_flag_o && !periph_rail_low_flag_o &&
		!periph_rail_low_i && !switch_overtemp_i && !supply_low_i) [*6] |-> !int_o) else $error("stray irq");
	chk_oe_frame: assert property ((!spi_cs_n_i) [*4] |-> spi_miso_oe_o) else
		$error("miso not driven in frame");
	chk_oe_idle: assert property (spi_cs_n_i [*4] |-> !spi_miso_oe_o) else
		$error("miso driven while deselected");
endmodule
bind cfm_can_fault_monitor cfm_chk u_chk (.*);

// ### test/tb.sv
`timescale 1ns/1ps
`include "cfm_cfg.svh"
module tb;
	logic mclk_i, rst_n_i, tx_i, periph_rail_low_i, main_rail_uv_i, rail_from_main_i;
	logic driver_overtemp_i, driver_overcurrent_i, bus_rx_i, switch_overtemp_i, supply_low_i;
	wire spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, driver_en_o, rx_o;
	wire can_sleep_o, reset_n_o, int_o, global_failure_flag_o, periph_rail_low_flag_o;
	int fails, cmp_count, cyc;
	logic [3:0] rd;
	// overtemp, rail low, bus level, then failure, driver, rx
	logic [5:0] rows [5] = '{6'h02, 6'h0b, 6'h2d, 6'h06, 6'h15};
	cfm_can_fault_monitor DUT (.*);
	cfm_host_model host (.mclk_i(mclk_i), .miso_i(spi_miso_o), .oe_i(spi_miso_oe_o), .cs_n_o(spi_cs_n_i),
		.sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i));
	task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xf(input logic [2:0] a, input logic w, input logic [3:0] d);
		host.xfer({a, w, d}, rd);
	endtask
	task automatic rc(input logic [2:0] a, input logic [3:0] exp);
		xf(a, 1'h0, 4'h0);
		chk("read", rd, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		mclk_i = 1'h0;
		forever #50 mclk_i = ~mclk_i;
	end
	// hang guard, well above the expected run
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		{rst_n_i, tx_i, periph_rail_low_i, main_rail_uv_i, rail_from_main_i} = 5'h08;
		{driver_overtemp_i, driver_overcurrent_i, bus_rx_i, switch_overtemp_i, supply_low_i} = 5'h00;
		wt(6);
		rst_n_i = 1'h1;
		wt(4);
		chk("idle_oe", 4'({spi_miso_oe_o, reset_n_o}), 4'h1);
		foreach (rows[i]) begin
			{driver_overtemp_i, periph_rail_low_i, bus_rx_i} = rows[i][5:3];
			wt(8);
			chk("fail_rx", 4'({global_failure_flag_o, rx_o}), 4'({rows[i][2], rows[i][0]}));
			chk("driver", 4'(driver_en_o), 4'(rows[i][1]));
		end
		// the rail-low flag survives a read while the cause is still present
		rc(`CFM_ADDR_IOR, 4'h1);
		periph_rail_low_i = 1'h0;
		rc(`CFM_ADDR_IOR, 4'h1);
		rc(`CFM_ADDR_CAN, 4'h2);
		chk("flags", 4'({global_failure_flag_o, periph_rail_low_flag_o}), 4'h0);
		xf(`CFM_ADDR_INTERRUPT_CONFIG_REGISTER, 1'h1, 4'ha);
		rc(`CFM_ADDR_INTERRUPT_CONFIG_REGISTER, 4'ha);
		for (int k = 0; k < 4; k++) begin
			{supply_low_i, switch_overtemp_i, periph_rail_low_i, driver_overcurrent_i} = 4'h1 << k;
			xf(`CFM_ADDR_INTERRUPT_CONFIG_REGISTER, 1'h1, 4'h1 << k);
			chk("irq_on", 4'(int_o), 4'h1);
			xf(`CFM_ADDR_INTERRUPT_CONFIG_REGISTER, 1'h1, 4'h0);
			chk("irq_off", 4'(int_o), 4'h0);
		end
		{supply_low_i, switch_overtemp_i, periph_rail_low_i, driver_overcurrent_i} = 4'h0;
		rc(`CFM_ADDR_CAN, 4'h1);
		rc(`CFM_ADDR_IOR, 4'h1);
		// stuck dominant transmit, with the can failure interrupt enabled
		xf(`CFM_ADDR_INTERRUPT_CONFIG_REGISTER, 1'h1, 4'h1);
		tx_i = 1'h0;
		wt(3590);
		chk("drv_early", 4'(driver_en_o), 4'h1);
		wt(20);
		chk("drv_cut", 4'({driver_en_o, global_failure_flag_o, int_o}), 4'h3);
		rc(`CFM_ADDR_CAN, 4'h4);
		rc(`CFM_ADDR_CAN, 4'h4);
		tx_i = 1'h1;
		wt(6);
		chk("drv_back", 4'(driver_en_o), 4'h1);
		rc(`CFM_ADDR_CAN, 4'h4);
		rc(`CFM_ADDR_CAN, 4'h0);
		// a short recessive gap restarts the count
		tx_i = 1'h0;
		wt(2000);
		tx_i = 1'h1;
		wt(2);
		tx_i = 1'h0;
		wt(2000);
		chk("drv_restart", 4'({driver_en_o, int_o}), 4'h2);
		tx_i = 1'h1;
		xf(`CFM_ADDR_CAN, 1'h1, `CFM_CAN_SLEEP_CMD);
		chk("sleep", 4'({can_sleep_o, rx_o}), 4'h3);
		xf(`CFM_ADDR_CAN, 1'h1, 4'h0);
		chk("awake", 4'({can_sleep_o, rx_o}), 4'h0);
		{main_rail_uv_i, rail_from_main_i} = 2'h3;
		wt(8);
		chk("uv", 4'({reset_n_o, periph_rail_low_flag_o}), 4'h1);
		main_rail_uv_i = 1'h0;
		wt(8);
		chk("uv_off", 4'(reset_n_o), 4'h1);
		rst_n_i = 1'h0;
		wt(3);
		chk("reset", 4'({driver_en_o, global_failure_flag_o, periph_rail_low_flag_o, int_o}), 4'h0);
		rst_n_i = 1'h1;
		wt(6);
		chk("restart", 4'({driver_en_o, reset_n_o, int_o}), 4'h6);
		wrap_up();
	end
endmodule
